/* rtl/azds_pkg.sv */
package azds_pkg;

	// ********************************************
	// widths
	// ********************************************
	localparam int AZDS_AZ_W = 12;
	localparam int AZDS_KIND_W = 4;
	localparam int AZDS_DATA_W = 56;
	localparam int AZDS_TIME_W = 32;

	// ********************************************
	// reset values
	// ********************************************
	localparam logic [AZDS_AZ_W-1:0] AZDS_AZ_RESET = 12'h000;
	localparam logic AZDS_MODE_RESET = 1'b0;

	// ********************************************
	// timing of the simulated antenna
	// ********************************************
	localparam int AZDS_CLK_PERIOD_NS = 10;
	localparam int AZDS_STEP_PERIOD_NS = 10000;
	localparam int AZDS_STEP_PERIOD_CYC = AZDS_STEP_PERIOD_NS / AZDS_CLK_PERIOD_NS;
	localparam int AZDS_STEPS_PER_REV = 4096;

	typedef enum logic {
		AZDS_MODE_DECODE,
		AZDS_MODE_SIMULATE
	} azds_mode_t;

	typedef struct packed {
		logic [AZDS_KIND_W-1:0] kind;
		logic [AZDS_TIME_W-1:0] arrival;
		logic [AZDS_AZ_W-1:0] azimuth;
		logic back_antenna;
		logic [AZDS_DATA_W-1:0] data;
	} azds_record_t;

	typedef struct packed {
		logic [AZDS_KIND_W-1:0] kind;
		logic back_antenna;
		logic [AZDS_DATA_W-1:0] data;
	} azds_intg_t;

endpackage : azds_pkg

/* rtl/azds_pulse_gen.sv */
`timescale 1ns/1ns
module azds_pulse_gen
	import azds_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic run_in,
	output logic step_out,
	output logic north_out
);

	localparam int CNT_W = $clog2(AZDS_STEP_PERIOD_CYC);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(AZDS_STEP_PERIOD_CYC - 1);
	localparam logic [AZDS_AZ_W-1:0] STEP_LAST = AZDS_AZ_W'(AZDS_STEPS_PER_REV - 1);

	logic [CNT_W-1:0] cnt_r;
	logic [AZDS_AZ_W-1:0] steps_r;
	logic tick;

	assign tick = run_in && (cnt_r == CNT_LAST);

	// counters park at zero while idle so a new run starts a clean revolution
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r <= '0;
		end else if (!run_in || tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			steps_r <= '0;
		end else if (!run_in) begin
			steps_r <= '0;
		end else if (tick) begin
			steps_r <= steps_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			step_out <= 1'b0;
			north_out <= 1'b0;
		end else begin
			step_out <= tick;
			north_out <= tick && (steps_r == STEP_LAST);
		end
	end

	a_gen_step_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		step_out |=> !step_out [*8])
		else $error("generated step pulses too close");

endmodule : azds_pulse_gen

/* rtl/azds_top.sv */
`timescale 1ns/1ns
module azds_top
	import azds_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic mode_sim_in,
	input wire logic azimuth_step_pulse_in,
	input wire logic north_reference_pulse_in,
	input wire logic intg_valid_in,
	input wire azds_intg_t intg_in,
	output logic azimuth_step_pulse_out,
	output logic north_reference_pulse_out,
	output logic [AZDS_AZ_W-1:0] azimuth_out,
	output logic record_valid_out,
	output azds_record_t record_out
);

	// ********************************************
	// antenna pin synchronisers
	// ********************************************
	logic step_s1_r, step_s2_r, step_s3_r;
	logic north_s1_r, north_s2_r, north_s3_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			step_s1_r <= 1'b0;
			step_s2_r <= 1'b0;
			step_s3_r <= 1'b0;
			north_s1_r <= 1'b0;
			north_s2_r <= 1'b0;
			north_s3_r <= 1'b0;
		end else begin
			step_s1_r <= azimuth_step_pulse_in;
			step_s2_r <= step_s1_r;
			step_s3_r <= step_s2_r;
			north_s1_r <= north_reference_pulse_in;
			north_s2_r <= north_s1_r;
			north_s3_r <= north_s2_r;
		end
	end

	logic ant_step_evt, ant_north_evt;
	assign ant_step_evt = step_s2_r && !step_s3_r;
	assign ant_north_evt = north_s2_r && !north_s3_r;

	// ********************************************
	// mode select
	// ********************************************
	azds_mode_t mode_r;

	// mode is a host level on this clock, taken without synchronising
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_r <= azds_mode_t'(AZDS_MODE_RESET);
		end else begin
			mode_r <= mode_sim_in ? AZDS_MODE_SIMULATE : AZDS_MODE_DECODE;
		end
	end

	logic sim_run;
	logic gen_step, gen_north;
	assign sim_run = (mode_r == AZDS_MODE_SIMULATE);

	azds_pulse_gen i_azds_pulse_gen (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.run_in(sim_run),
		.step_out(gen_step),
		.north_out(gen_north)
	);

	// ********************************************
	// azimuth register
	// ********************************************
	logic step_evt, north_evt;
	logic [AZDS_AZ_W-1:0] az_r;
	logic [AZDS_AZ_W-1:0] az_nxt;

	always_comb begin
		step_evt = 1'b0;
		north_evt = 1'b0;
		unique case (mode_r)
			AZDS_MODE_DECODE: begin
				step_evt = ant_step_evt;
				north_evt = ant_north_evt;
			end
			AZDS_MODE_SIMULATE: begin
				step_evt = gen_step;
				north_evt = gen_north;
			end
		endcase
	end

	// north wins over a coincident step: the reference defines position zero
	always_comb begin
		az_nxt = az_r;
		if (north_evt) begin
			az_nxt = AZDS_AZ_RESET;
		end else if (step_evt) begin
			az_nxt = az_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			az_r <= AZDS_AZ_RESET;
		end else begin
			az_r <= az_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			azimuth_out <= AZDS_AZ_RESET;
		end else begin
			azimuth_out <= az_nxt;
		end
	end

	// ********************************************
	// pulses to the sensor
	// ********************************************
	// decoder mode repeats the synchronised level, so pulse width is kept;
	// the cost is three cycles of latency through the chain
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			azimuth_step_pulse_out <= 1'b0;
			north_reference_pulse_out <= 1'b0;
		end else if (sim_run) begin
			azimuth_step_pulse_out <= gen_step;
			north_reference_pulse_out <= gen_north;
		end else begin
			azimuth_step_pulse_out <= step_s2_r;
			north_reference_pulse_out <= north_s2_r;
		end
	end

	// ********************************************
	// interrogation records
	// ********************************************
	logic [AZDS_TIME_W-1:0] time_r;

	// free-running arrival clock; wraps silently
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			time_r <= '0;
		end else begin
			time_r <= time_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			record_valid_out <= 1'b0;
		end else begin
			record_valid_out <= intg_valid_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			record_out <= '0;
		end else if (intg_valid_in) begin
			record_out.kind <= intg_in.kind;
			record_out.arrival <= time_r;
			record_out.data <= intg_in.data;
			record_out.azimuth <= az_r;
			record_out.back_antenna <= intg_in.back_antenna;
		end
	end

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_mode_select: assert property (mode_sim_in |=> sim_run)
		else $error("simulator mode not entered");
	a_dec_step_inc: assert property (!sim_run && ant_step_evt && !ant_north_evt
		|=> az_r == $past(az_r) + 1'b1)
		else $error("decoder step did not advance azimuth");
	a_dec_north_clr: assert property (!sim_run && ant_north_evt |=> az_r == AZDS_AZ_RESET)
		else $error("decoder north did not clear azimuth");
	// a one-cycle antenna pulse leaves the sensor line after exactly three edges
	a_dec_step_fwd: assert property (!sim_run && $rose(azimuth_step_pulse_in)
		##1 !sim_run [*2] |=> azimuth_step_pulse_out)
		else $error("antenna step not repeated to sensor");
	a_dec_north_fwd: assert property (!sim_run
		|=> north_reference_pulse_out == $past(north_s2_r))
		else $error("antenna north not repeated to sensor");
	a_sim_drive: assert property (sim_run && gen_north
		|=> north_reference_pulse_out && az_r == AZDS_AZ_RESET)
		else $error("generated north not driven or applied");
	// north only comes once a revolution, so the step path carries most of the checking
	a_sim_step_drive: assert property (sim_run && gen_step
		|=> azimuth_step_pulse_out && north_reference_pulse_out == $past(gen_north)
		&& az_r == ($past(gen_north) ? AZDS_AZ_RESET : $past(az_r) + 1'b1))
		else $error("generated step not driven or applied");
	a_sim_ignore: assert property (sim_run && !gen_step && !gen_north
		|=> az_r == $past(az_r) && !azimuth_step_pulse_out)
		else $error("antenna pulse leaked in simulator mode");
	a_rec_fields: assert property (intg_valid_in |=> record_valid_out
		&& record_out.kind == $past(intg_in.kind) && record_out.arrival == $past(time_r))
		else $error("record kind or arrival wrong");
	a_rec_azimuth: assert property (intg_valid_in |=> record_out.azimuth == $past(az_r))
		else $error("record azimuth not from azimuth register");
	a_rec_side: assert property (intg_valid_in ##1 !intg_valid_in
		|-> record_out.back_antenna == $past(intg_in.back_antenna))
		else $error("record antenna flag wrong");

	c_dec_wrap: cover property (!sim_run && ant_north_evt ##[1:20] ant_step_evt);
	c_sim_north: cover property (sim_run && gen_north);
	c_sim_step: cover property (sim_run && gen_step);
	c_rec_pair: cover property (intg_valid_in ##1 intg_valid_in);

endmodule : azds_top

/* bench/azds_far_model.sv */
`timescale 1ns/1ns
module azds_far_model (
	input wire logic clk_in,
	input wire logic step_in,
	input wire logic north_in,
	output logic step_out,
	output logic north_out
);
	int step_cnt = 0;
	int north_cnt = 0;
	logic step_d = 1'b0;
	logic north_d = 1'b0;
	initial begin
		step_out = 1'b0;
		north_out = 1'b0;
	end
	// ********
	// sensor side: counts rising edges that reach it
	// ********
	always @(posedge clk_in) begin
		step_d <= step_in;
		north_d <= north_in;
		if (step_in && !step_d) begin
			step_cnt <= step_cnt + 1;
		end
		if (north_in && !north_d) begin
			north_cnt <= north_cnt + 1;
		end
	end
	// antenna side; hold varies so fast and slow pulses both occur
	task automatic pulse(input bit north, input int hold);
		@(posedge clk_in);
		if (north) begin
			north_out <= 1'b1;
		end else begin
			step_out <= 1'b1;
		end
		repeat (hold) @(posedge clk_in);
		north_out <= 1'b0;
		step_out <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask : pulse
endmodule : azds_far_model

/* bench/azds_top_tb.sv */
`timescale 1ns/1ns
module azds_top_tb;
	import azds_pkg::*;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic mode_sim_in = 1'b0;
	logic ant_step, ant_north, step_s, north_s, intg_valid_in, record_valid_out;
	azds_intg_t intg_in = '0;
	azds_record_t record_out, n;
	logic [AZDS_AZ_W-1:0] azimuth_out;
	logic [AZDS_AZ_W-1:0] exp_az = 12'h000;
	logic [AZDS_TIME_W-1:0] now_cnt = '0;
	azds_record_t exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 32'h456c;
	int sc;
	initial intg_valid_in = 1'b0;
	initial forever #5 clk_in = ~clk_in;
	azds_far_model i_azds_far_model (.clk_in(clk_in), .step_in(step_s), .north_in(north_s),
		.step_out(ant_step), .north_out(ant_north));
	azds_top i_azds_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .mode_sim_in(mode_sim_in),
		.azimuth_step_pulse_in(ant_step), .north_reference_pulse_in(ant_north),
		.intg_valid_in(intg_valid_in), .intg_in(intg_in), .azimuth_step_pulse_out(step_s),
		.north_reference_pulse_out(north_s), .azimuth_out(azimuth_out),
		.record_valid_out(record_valid_out), .record_out(record_out));
	// ********
	// shared tasks
	// ********
	task automatic check_val(input string what, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", what, e, g);
		end
	endtask : check_val
	task automatic complete_run;
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic steps(input int cnt);
		repeat (cnt) begin
			i_azds_far_model.pulse(1'b0, ($random(seed) & 3) + 1);
			if (!mode_sim_in) exp_az++;
		end
		repeat (4) @(posedge clk_in);
	endtask : steps
	task automatic intg(input int cnt);
		azds_intg_t v;
		for (int i = 0; i < cnt; i++) begin
			v.kind = $random(seed);
			v.back_antenna = $random(seed);
			v.data = {$random(seed), $random(seed)};
			@(posedge clk_in);
			intg_valid_in <= 1'b1;
			intg_in <= v;
			exp_q.push_back({v.kind, now_cnt + 32'h1, exp_az, v.back_antenna, v.data});
		end
		@(posedge clk_in);
		intg_valid_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : intg
	// ********
	// record monitor
	// ********
	// cycles since reset release; the take edge is one later than the push
	always @(posedge clk_in) begin
		if (reset_n_in) begin
			now_cnt <= now_cnt + 32'h1;
		end
	end
	always @(posedge clk_in) begin
		if (record_valid_out === 1'b1) begin
			n = exp_q.pop_front();
			check_val("kind", n.kind, record_out.kind);
			check_val("azimuth", n.azimuth, record_out.azimuth);
			check_val("back flag", n.back_antenna, record_out.back_antenna);
			check_val("data", n.data, record_out.data);
			check_val("arrival", n.arrival, record_out.arrival);
		end
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		check_val("reset azimuth", 12'h000, azimuth_out);
		steps(5);
		check_val("decoded azimuth", exp_az, azimuth_out);
		check_val("steps repeated", 5, i_azds_far_model.step_cnt);
		intg(3);
		i_azds_far_model.pulse(1'b1, 2);
		exp_az = 12'h000;
		repeat (4) @(posedge clk_in);
		check_val("north clear", exp_az, azimuth_out);
		check_val("north repeated", 1, i_azds_far_model.north_cnt);
		sc = i_azds_far_model.step_cnt;
		mode_sim_in <= 1'b1;
		steps(4);
		check_val("ignored steps", 0, i_azds_far_model.step_cnt - sc);
		repeat (2100) @(posedge clk_in);
		exp_az = 12'h002;
		check_val("sim azimuth", exp_az, azimuth_out);
		check_val("sim steps", 2, i_azds_far_model.step_cnt - sc);
		intg(1);
		mode_sim_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		steps(1);
		check_val("decode again", exp_az, azimuth_out);
		for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk_in);
		check_val("pending records", 0, exp_q.size());
		complete_run();
	end
endmodule : azds_top_tb
